// ==== dlf_defs.vh ====
// Register map, field layout and reset values of the linked-list DMA channel controller.
// Function
// - Entry config with companion enable cleared finishes, then list execution stops.
// - Last next-pointer equal to list base refetches the first entry, circular list.
// - Entry writing the soft-interrupt register raises the soft interrupt output.
// - Soft-interrupt entry placed before final entry signals before the final transfer.
// - Reload companion bit cleared: entry completes, loads first channel, does not enable.
// - Single request flow control; multi-word burst requests are not supported.
// - Requests and external enables are synchronised by two flip-flops internally.
// - Request lines 0 to 19, 14 and 15 reserved; select value is line plus one.
// - A buffered level slave may see two transfers; count is never exceeded.
// - Each of channels 0 to 11 starts from its own external enable once it has passed the two-flop synchroniser.
// - Acknowledge rises when the channel finishes, falls after external enable drops.
// - External enable only starts a channel, once per full handshake.
// - Every channel finish pulses its acknowledge for at least one clock.
// - Each entry is five words: source, destination, length, configuration, next.
`ifndef DLF_DEFS_VH
`define DLF_DEFS_VH
`define DLF_NCH 4'hC
`define DLF_NLINE 5'h14
`define DLF_RSV_LINE_A 5'h0E
`define DLF_RSV_LINE_B 5'h0F
`define DLF_REG_BASE 32'hF000_0000
`define DLF_REGION_CH 2'h0
`define DLF_REGION_GLB 2'h1
`define DLF_W_SRC 4'h0
`define DLF_W_DST 4'h1
`define DLF_W_LEN 4'h2
`define DLF_W_CFG 4'h3
`define DLF_W_EN 4'h4
`define DLF_W_CNT 4'h5
`define DLF_W_ASRC 4'h8
`define DLF_W_ADST 4'h9
`define DLF_W_ALEN 4'hA
`define DLF_W_ACFG 4'hB
`define DLF_W_ANXT 4'hC
`define DLF_G_SOFT 4'h0
`define DLF_G_BUSY 4'h1
`define DLF_ALT_OFS 12'h020
`define DLF_CFG_COMP_MSB 3
`define DLF_CFG_COMP_LSB 0
`define DLF_CFG_COMP_EN 4
`define DLF_CFG_PSEL_MSB 9
`define DLF_CFG_PSEL_LSB 5
`define DLF_WORD_STEP 32'h0000_0004
`define DLF_RST_WORD 32'h0000_0000
`define DLF_RESP_OKAY 2'h0
`define DLF_RESP_SLVERR 2'h2
`endif

// ==== dlf_dma_ctrl.v ====
// Channel control of a twelve-channel DMA with linked lists, flow control and external enables.
`timescale 1ns/1ps
`include "dlf_defs.vh"
module dlf_dma_ctrl (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire mem_req,
  output wire mem_we,
  output wire [31:0] mem_addr,
  output wire [31:0] mem_wdata,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  input wire [19:0] peripheral_single_request_input,
  output wire [19:0] transfer_clear_output,
  input wire [11:0] ext_en,
  output wire [11:0] ext_en_ack,
  output wire soft_int
);

localparam [4:0] ST_IDLE = 5'h01;
localparam [4:0] ST_RD = 5'h02;
localparam [4:0] ST_WR = 5'h04;
localparam [4:0] ST_IW = 5'h08;
localparam [4:0] ST_NX = 5'h10;

reg [31:0] src_reg [0:11];
reg [31:0] dst_reg [0:11];
reg [31:0] len_reg [0:11];
reg [31:0] cfg_reg [0:11];
reg [31:0] cnt_reg [0:11];
reg [31:0] asrc_reg [0:11];
reg [31:0] adst_reg [0:11];
reg [31:0] alen_reg [0:11];
reg [31:0] acfg_reg [0:11];
reg [31:0] anxt_reg [0:11];
reg [11:0] en_reg;
reg [11:0] altv_reg;
reg [11:0] ext_s1_reg;
reg [11:0] ext_s2_reg;
reg [11:0] ext_done_reg;
reg [11:0] ack_reg;
reg [19:0] single_transfer_request_s1_reg;
reg [19:0] single_transfer_request_s2_reg;
reg [19:0] clr_reg;
reg [19:0] clr_d_reg;
reg soft_reg;
reg [4:0] st_reg;
reg [3:0] cur_reg;
reg [31:0] data_reg;
reg mreq_reg;
reg mwe_reg;
reg [31:0] maddr_reg;
reg [31:0] mwdata_reg;
reg awrdy_reg;
reg wrdy_reg;
reg [11:0] awa_reg;
reg [31:0] wd_reg;
reg [3:0] ws_reg;
reg bv_reg;
reg [1:0] br_reg;
reg arrdy_reg;
reg rv_reg;
reg [31:0] rd_reg;
reg [1:0] rr_reg;
reg [3:0] gnt;
reg gnt_any;
reg [31:0] rd_word;
integer i;
integer j;

// Single requests only: a burst line wider than one word has no input here.
function req_ok;
  input [31:0] cfg;
  input [19:0] single_transfer_request;
  reg [4:0] ps;
  begin
    ps = cfg[`DLF_CFG_PSEL_MSB:`DLF_CFG_PSEL_LSB];
    if (ps == 5'h00)
      req_ok = 1'b1;
    else if (ps > `DLF_NLINE)
      req_ok = 1'b0;
    else if ((ps - 5'h01) == `DLF_RSV_LINE_A || (ps - 5'h01) == `DLF_RSV_LINE_B)
      req_ok = 1'b0;
    else
      req_ok = single_transfer_request[ps - 5'h01];
  end
endfunction

function [31:0] merge;
  input [31:0] old;
  input [31:0] d;
  input [3:0] s;
  begin
    merge = {s[3] ? d[31:24] : old[31:24], s[2] ? d[23:16] : old[23:16],
             s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  end
endfunction

function hit;
  input [11:0] a;
  begin
    if (a[11:10] == `DLF_REGION_CH)
      hit = (a[9:6] < `DLF_NCH) && (a[5:2] <= `DLF_W_CNT ||
            (a[5:2] >= `DLF_W_ASRC && a[5:2] <= `DLF_W_ANXT));
    else if (a[11:10] == `DLF_REGION_GLB)
      hit = (a[9:6] == 4'h0) && (a[5:2] <= `DLF_G_BUSY);
    else
      hit = 1'b0;
  end
endfunction

wire [31:0] cur_cfg = cfg_reg[cur_reg];
wire [31:0] cur_dst = dst_reg[cur_reg];
wire [3:0] cpn = cur_cfg[`DLF_CFG_COMP_MSB:`DLF_CFG_COMP_LSB];
wire [4:0] cur_ps = cur_cfg[`DLF_CFG_PSEL_MSB:`DLF_CFG_PSEL_LSB];
wire dst_is_reg = (cur_dst[31:12] == `DLF_REG_BASE >> 12);
wire eng_iw = (st_reg == ST_IW);
wire axi_wr = ~awrdy_reg & ~wrdy_reg & ~bv_reg & ~eng_iw;
wire wr_go = eng_iw | axi_wr;
wire [11:0] wa = eng_iw ? cur_dst[11:0] : awa_reg;
wire [31:0] wd = eng_iw ? data_reg : wd_reg;
wire [3:0] wm = eng_iw ? 4'hF : ws_reg;
wire [3:0] wc = wa[9:6];
wire wr_ch = wr_go && wa[11:10] == `DLF_REGION_CH && wc < `DLF_NCH && hit(wa);
wire wr_soft = wr_go && hit(wa) && wa[11:10] == `DLF_REGION_GLB && wa[5:2] == `DLF_G_SOFT;
wire [3:0] rc = s_axi_araddr[9:6];

always @* begin
  gnt = 4'h0;
  gnt_any = 1'b0;
  // A cleared line stays masked until its synchroniser shows the level after the clear,
  // otherwise a stale request would move one word more than the peripheral asked for.
  for (j = 11; j >= 0; j = j - 1) begin
    if (en_reg[j] && req_ok(cfg_reg[j], single_transfer_request_s2_reg & ~clr_reg & ~clr_d_reg)) begin
      gnt = j[3:0];
      gnt_any = 1'b1;
    end
  end
end

always @* begin
  rd_word = `DLF_RST_WORD;
  if (s_axi_araddr[11:10] == `DLF_REGION_GLB) begin
    if (s_axi_araddr[5:2] == `DLF_G_SOFT)
      rd_word = {31'h0000_0000, soft_reg};
    else
      rd_word = {20'h0_0000, en_reg};
  end else if (rc < `DLF_NCH) begin
    case (s_axi_araddr[5:2])
      `DLF_W_SRC: rd_word = src_reg[rc];
      `DLF_W_DST: rd_word = dst_reg[rc];
      `DLF_W_LEN: rd_word = len_reg[rc];
      `DLF_W_CFG: rd_word = cfg_reg[rc];
      `DLF_W_EN: rd_word = {31'h0000_0000, en_reg[rc]};
      `DLF_W_CNT: rd_word = cnt_reg[rc];
      `DLF_W_ASRC: rd_word = asrc_reg[rc];
      `DLF_W_ADST: rd_word = adst_reg[rc];
      `DLF_W_ALEN: rd_word = alen_reg[rc];
      `DLF_W_ACFG: rd_word = acfg_reg[rc];
      `DLF_W_ANXT: rd_word = anxt_reg[rc];
      default: rd_word = `DLF_RST_WORD;
    endcase
  end
end

always @(posedge aclk) begin
  if (!aresetn) begin
    for (i = 0; i < 12; i = i + 1) begin
      src_reg[i] <= `DLF_RST_WORD;
      dst_reg[i] <= `DLF_RST_WORD;
      len_reg[i] <= `DLF_RST_WORD;
      cfg_reg[i] <= `DLF_RST_WORD;
      cnt_reg[i] <= `DLF_RST_WORD;
      asrc_reg[i] <= `DLF_RST_WORD;
      adst_reg[i] <= `DLF_RST_WORD;
      alen_reg[i] <= `DLF_RST_WORD;
      acfg_reg[i] <= `DLF_RST_WORD;
      anxt_reg[i] <= `DLF_RST_WORD;
    end
    en_reg <= 12'h000;
    altv_reg <= 12'h000;
    ext_s1_reg <= 12'h000;
    ext_s2_reg <= 12'h000;
    ext_done_reg <= 12'h000;
    ack_reg <= 12'h000;
    single_transfer_request_s1_reg <= 20'h0_0000;
    single_transfer_request_s2_reg <= 20'h0_0000;
    clr_reg <= 20'h0_0000;
    clr_d_reg <= 20'h0_0000;
    soft_reg <= 1'b0;
    st_reg <= ST_IDLE;
    cur_reg <= 4'h0;
    data_reg <= `DLF_RST_WORD;
    mreq_reg <= 1'b0;
    mwe_reg <= 1'b0;
    maddr_reg <= `DLF_RST_WORD;
    mwdata_reg <= `DLF_RST_WORD;
    awrdy_reg <= 1'b1;
    wrdy_reg <= 1'b1;
    awa_reg <= 12'h000;
    wd_reg <= `DLF_RST_WORD;
    ws_reg <= 4'h0;
    bv_reg <= 1'b0;
    br_reg <= `DLF_RESP_OKAY;
    arrdy_reg <= 1'b1;
    rv_reg <= 1'b0;
    rd_reg <= `DLF_RST_WORD;
    rr_reg <= `DLF_RESP_OKAY;
  end else begin
    // Peripherals may run on any clock, so every request passes two flops.
    single_transfer_request_s1_reg <= peripheral_single_request_input;
    single_transfer_request_s2_reg <= single_transfer_request_s1_reg;
    ext_s1_reg <= ext_en;
    ext_s2_reg <= ext_s1_reg;
    clr_reg <= 20'h0_0000;
    clr_d_reg <= clr_reg;
    // ---------------------------------------------------------------
    // Register bus slave
    // ---------------------------------------------------------------
    if (awrdy_reg && s_axi_awvalid) begin
      awrdy_reg <= 1'b0;
      awa_reg <= s_axi_awaddr;
    end
    if (wrdy_reg && s_axi_wvalid) begin
      wrdy_reg <= 1'b0;
      wd_reg <= s_axi_wdata;
      ws_reg <= s_axi_wstrb;
    end
    if (axi_wr) begin
      bv_reg <= 1'b1;
      br_reg <= hit(awa_reg) ? `DLF_RESP_OKAY : `DLF_RESP_SLVERR;
      awrdy_reg <= 1'b1;
      wrdy_reg <= 1'b1;
    end
    if (bv_reg && s_axi_bready)
      bv_reg <= 1'b0;
    if (arrdy_reg && s_axi_arvalid) begin
      arrdy_reg <= 1'b0;
      rv_reg <= 1'b1;
      rd_reg <= rd_word;
      rr_reg <= hit(s_axi_araddr) ? `DLF_RESP_OKAY : `DLF_RESP_SLVERR;
    end
    if (rv_reg && s_axi_rready) begin
      rv_reg <= 1'b0;
      arrdy_reg <= 1'b1;
    end
    // Descriptor words reach the alternate slots through this same port.
    if (wr_ch) begin
      case (wa[5:2])
        `DLF_W_SRC: src_reg[wc] <= merge(src_reg[wc], wd, wm);
        `DLF_W_DST: dst_reg[wc] <= merge(dst_reg[wc], wd, wm);
        `DLF_W_LEN: len_reg[wc] <= merge(len_reg[wc], wd, wm);
        `DLF_W_CFG: cfg_reg[wc] <= merge(cfg_reg[wc], wd, wm);
        `DLF_W_EN: begin
          if (wm[0]) begin
            en_reg[wc] <= wd[0];
            if (wd[0])
              cnt_reg[wc] <= len_reg[wc];
          end
        end
        `DLF_W_ASRC: asrc_reg[wc] <= merge(asrc_reg[wc], wd, wm);
        `DLF_W_ADST: adst_reg[wc] <= merge(adst_reg[wc], wd, wm);
        `DLF_W_ALEN: alen_reg[wc] <= merge(alen_reg[wc], wd, wm);
        `DLF_W_ACFG: acfg_reg[wc] <= merge(acfg_reg[wc], wd, wm);
        `DLF_W_ANXT: begin
          anxt_reg[wc] <= merge(anxt_reg[wc], wd, wm);
          if (eng_iw)
            altv_reg[wc] <= 1'b1;
        end
        default: ;
      endcase
    end
    // A bus clear is held off while the engine writes, so the engine's set never meets a clear in the same cycle.
    if (wr_soft && !eng_iw && wm[0] && wd[0])
      soft_reg <= 1'b0;
    if (wr_soft && eng_iw)
      soft_reg <= 1'b1;
    // ---------------------------------------------------------------
    // External enable handshake
    // ---------------------------------------------------------------
    for (i = 0; i < 12; i = i + 1) begin
      if (ext_s2_reg[i] && !ext_done_reg[i]) begin
        en_reg[i] <= 1'b1;
        cnt_reg[i] <= len_reg[i];
        ext_done_reg[i] <= 1'b1;
      end else if (!ext_s2_reg[i] && !ack_reg[i]) begin
        ext_done_reg[i] <= 1'b0;
      end
      if (!ext_s2_reg[i])
        ack_reg[i] <= 1'b0;
    end
    // ---------------------------------------------------------------
    // Transfer engine
    // ---------------------------------------------------------------
    case (st_reg)
      ST_IDLE: begin
        if (gnt_any) begin
          cur_reg <= gnt;
          mreq_reg <= 1'b1;
          mwe_reg <= 1'b0;
          maddr_reg <= src_reg[gnt];
          st_reg <= ST_RD;
        end
      end
      ST_RD: begin
        if (mem_ack) begin
          data_reg <= mem_rdata;
          if (dst_is_reg) begin
            mreq_reg <= 1'b0;
            st_reg <= ST_IW;
          end else begin
            mwe_reg <= 1'b1;
            maddr_reg <= cur_dst;
            mwdata_reg <= mem_rdata;
            st_reg <= ST_WR;
          end
        end
      end
      ST_WR: begin
        if (mem_ack) begin
          mreq_reg <= 1'b0;
          mwe_reg <= 1'b0;
          st_reg <= ST_NX;
        end
      end
      ST_IW: st_reg <= ST_NX;
      ST_NX: begin
        st_reg <= ST_IDLE;
        src_reg[cur_reg] <= src_reg[cur_reg] + `DLF_WORD_STEP;
        dst_reg[cur_reg] <= cur_dst + `DLF_WORD_STEP;
        if (cur_ps != 5'h00 && cur_ps <= `DLF_NLINE)
          clr_reg[cur_ps - 5'h01] <= 1'b1;
        if (cnt_reg[cur_reg] != `DLF_RST_WORD) begin
          cnt_reg[cur_reg] <= cnt_reg[cur_reg] - 32'h0000_0001;
        end else begin
          // Finished: the counter never goes below zero, so no extra word follows.
          en_reg[cur_reg] <= 1'b0;
          ack_reg[cur_reg] <= 1'b1;
          if (cpn < `DLF_NCH && cpn != cur_reg) begin
            if (altv_reg[cpn]) begin
              // Reload channel done: move the fetched entry into the companion.
              src_reg[cpn] <= asrc_reg[cpn];
              dst_reg[cpn] <= adst_reg[cpn];
              len_reg[cpn] <= alen_reg[cpn];
              cfg_reg[cpn] <= acfg_reg[cpn];
              cnt_reg[cpn] <= alen_reg[cpn];
              altv_reg[cpn] <= 1'b0;
              src_reg[cur_reg] <= anxt_reg[cpn];
              dst_reg[cur_reg] <= `DLF_REG_BASE | {20'h0_0000, 2'h0, cpn, 6'h00}
                                  | {20'h0_0000, `DLF_ALT_OFS};
            end else if (cur_cfg[`DLF_CFG_COMP_EN]) begin
              // Without a link the companion's counter is reloaded from its length in the same cycle it is enabled.
              cnt_reg[cpn] <= len_reg[cpn];
            end
            // A cleared companion enable ends the list after this entry.
            if (cur_cfg[`DLF_CFG_COMP_EN])
              en_reg[cpn] <= 1'b1;
          end
        end
      end
      default: st_reg <= ST_IDLE;
    endcase
  end
end

assign s_axi_awready = awrdy_reg;
assign s_axi_wready = wrdy_reg;
assign s_axi_bvalid = bv_reg;
assign s_axi_bresp = br_reg;
assign s_axi_arready = arrdy_reg;
assign s_axi_rvalid = rv_reg;
assign s_axi_rdata = rd_reg;
assign s_axi_rresp = rr_reg;
assign mem_req = mreq_reg;
assign mem_we = mwe_reg;
assign mem_addr = maddr_reg;
assign mem_wdata = mwdata_reg;
assign transfer_clear_output = clr_reg;
assign ext_en_ack = ack_reg;
assign soft_int = soft_reg;

endmodule // dlf_dma_ctrl

// ==== dlf_asserts.sv ====
// Port-level checker for the DMA channel controller.
`timescale 1ns/1ps
module dlf_asserts (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire mem_ack,
  input wire [19:0] transfer_clear_output,
  input wire [11:0] ext_en,
  input wire [11:0] ext_en_ack,
  input wire soft_int
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Handshakes
  // ----------------------------------------
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_MEM_STANDS: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before ack");
  // ----------------------------------------
  // Flow control, external enable and soft interrupt
  // ----------------------------------------
  AST_CLR_ONE_CYCLE: assert property (transfer_clear_output != 20'h00000 |=>
    (transfer_clear_output & $past(transfer_clear_output)) == 20'h00000)
    else $error("clear pulse longer than one cycle");
  AST_CLR_RESERVED: assert property (transfer_clear_output[15:14] == 2'h0)
    else $error("clear on reserved line");
  AST_CLR_AFTER_WRITE: assert property (transfer_clear_output != 20'h00000 |->
    $past(mem_ack && mem_we, 1) || $past(mem_ack && mem_we, 2))
    else $error("clear without a completed write");
  AST_EXT_START: assert property ($rose(ext_en[4]) && !ext_en_ack[4] && !mem_req |->
    ##[2:8] mem_req)
    else $error("external enable did not start the channel");
  AST_ACK_HOLD: assert property (ext_en_ack[4] && ext_en[4] && $past(ext_en[4]) |=> ext_en_ack[4])
    else $error("acknowledge dropped while enable held");
  AST_ACK_RELEASE: assert property ($fell(ext_en[4]) |-> ##[1:4] !ext_en_ack[4])
    else $error("acknowledge not released");
  AST_SOFT_HOLDS: assert property (soft_int && s_axi_awready && !s_axi_awvalid |=> soft_int)
    else $error("soft interrupt lost without a clear");
  COV_SOFT: cover property ($rose(soft_int));
  COV_ACK: cover property ($rose(ext_en_ack[4]));
  COV_CLR: cover property (transfer_clear_output[2]);
endmodule // dlf_asserts

bind dlf_dma_ctrl dlf_asserts u_asserts (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_ack(mem_ack), .transfer_clear_output(transfer_clear_output), .ext_en(ext_en),
  .ext_en_ack(ext_en_ack), .soft_int(soft_int)
);

// ==== dlf_far_model.sv ====
// Far side: word memory with adjustable latency and one FIFO-level peripheral.
`timescale 1ns/1ps
module dlf_far_model #(
  parameter LINE = 2
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] lat,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  output logic mem_ack,
  output wire [31:0] mem_rdata,
  input wire lvl_wr,
  input wire [3:0] lvl_val,
  input wire [19:0] transfer_clear_output,
  output wire [19:0] peripheral_single_request_input
);
  logic [31:0] mem [0:255];
  logic [31:0] rd_reg;
  logic [3:0] wait_reg;
  logic [3:0] lvl_reg;
  initial for (int i = 0; i < 256; i++) mem[i] = 32'h0;
  // Outside an ack the read bus shows the inverse of the last word, so a stale sample shows up.
  assign mem_rdata = mem_ack ? rd_reg : ~rd_reg;
  always @(posedge aclk) begin
    mem_ack <= 1'b0;
    if (!aresetn) begin
      wait_reg <= 4'h0;
      rd_reg <= 32'h0;
    end else if (mem_req && !mem_ack && wait_reg >= lat) begin
      mem_ack <= 1'b1;
      wait_reg <= 4'h0;
      rd_reg <= mem[mem_addr[9:2]];
      if (mem_we) mem[mem_addr[9:2]] <= mem_wdata;
    end else if (mem_req) wait_reg <= wait_reg + 4'h1;
  end
  always @(posedge aclk) begin
    if (!aresetn) lvl_reg <= 4'h0;
    else if (lvl_wr) lvl_reg <= lvl_val;
    else if (transfer_clear_output[LINE] && lvl_reg != 4'h0) lvl_reg <= lvl_reg - 4'h1;
  end
  assign peripheral_single_request_input =
    (lvl_reg != 4'h0 && !transfer_clear_output[LINE]) ? (20'h00001 << LINE) : 20'h00000;
endmodule // dlf_far_model

// ==== dma_linked_list_flow_control_tb_top.sv ====
// Self-checking bench for lists, request flow control and external enables.
`timescale 1ns/1ps
module dma_linked_list_flow_control_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [11:0] ext_en = 12'h000;
  logic [3:0] lat = 4'h0;
  logic lvl_wr = 1'b0;
  logic [3:0] lvl_val = 4'h0;
  logic ack0_seen = 1'b0;
  logic [1:0] r;
  logic [31:0] d;
  int i;
  int mismatches = 0;
  int num_checks = 0;
  wire awready, wready, bvalid, arready, rvalid, mem_req, mem_we, mem_ack, soft_int;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, mem_addr, mem_wdata, mem_rdata;
  wire [19:0] single_transfer_request, clr;
  wire [11:0] ext_en_ack;
  logic [31:0] ll [0:14] = '{32'h0, 32'h80, 32'h0, 32'h11, 32'h114, 32'h4, 32'hF000_0400,
    32'h0, 32'h11, 32'h128, 32'h8, 32'h84, 32'h0, 32'h0, 32'h0};
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) if (ext_en_ack[0] === 1'b1) ack0_seen <= 1'b1;
  dlf_dma_ctrl dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .peripheral_single_request_input(single_transfer_request),
    .transfer_clear_output(clr), .ext_en(ext_en), .ext_en_ack(ext_en_ack), .soft_int(soft_int)
  );
  dlf_far_model u_mem (
    .aclk(aclk), .aresetn(aresetn), .lat(lat), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .lvl_wr(lvl_wr), .lvl_val(lvl_val), .transfer_clear_output(clr),
    .peripheral_single_request_input(single_transfer_request)
  );
  // ----------------------------------------
  // Bus and helper tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rr);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && !awvalid && !wvalid) && !bvalid);
    rr = bresp;
    bready <= 1'b0;
  endtask
  task automatic w(input logic [11:0] a, input logic [31:0] v);
    logic [1:0] rr;
    wr(a, v, rr);
    chk({30'h0, rr}, 32'h0);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rr);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rr;
    rd(a, v, rr);
    chk(v, e);
  endtask
  task automatic poll(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rr;
    v = ~e;
    for (int k = 0; k < 300 && v !== e; k++) rd(a, v, rr);
    chk(v, e);
  endtask
  task automatic wait_mem(input int idx, input logic [31:0] e);
    for (int k = 0; k < 3000 && u_mem.mem[idx] !== e; k++) @(posedge aclk);
    chk(u_mem.mem[idx], e);
  endtask
  task automatic lvl(input logic [3:0] v);
    @(posedge aclk);
    lvl_val <= v;
    lvl_wr <= 1'b1;
    @(posedge aclk);
    lvl_wr <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(12'h404, 32'h0);
    rd(12'h300, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, 32'h2);
    wr(12'h300, 32'h1, r);
    chk({30'h0, r}, 32'h2);
    for (i = 0; i < 15; i++) u_mem.mem[64 + i] = ll[i];
    u_mem.mem[0] = 32'hA5A5_0001;
    u_mem.mem[1] = 32'h1;
    u_mem.mem[2] = 32'h5A5A_0003;
    u_mem.mem[3] = 32'h0000_C0DE;
    w(12'h040, 32'h100);
    w(12'h044, 32'hF000_0020);
    w(12'h048, 32'h4);
    w(12'h04C, 32'h10);
    w(12'h050, 32'h1);
    for (i = 0; i < 3000 && soft_int !== 1'b1; i++) @(posedge aclk);
    chk({31'h0, soft_int}, 32'h1);
    chk(u_mem.mem[33], 32'h0);
    wait_mem(33, 32'h5A5A_0003);
    poll(12'h404, 32'h0);
    chk(u_mem.mem[32], 32'hA5A5_0001);
    chk({31'h0, ack0_seen}, 32'h1);
    rchk(12'h400, 32'h1);
    w(12'h400, 32'h1);
    rchk(12'h400, 32'h0);
    lat <= 4'h3;
    lvl(4'h2);
    w(12'h000, 32'h0);
    w(12'h004, 32'hC0);
    w(12'h008, 32'h3);
    w(12'h00C, 32'h60);
    w(12'h010, 32'h1);
    wait_mem(49, 32'h1);
    repeat (40) @(posedge aclk);
    chk(u_mem.mem[50], 32'h0);
    rchk(12'h014, 32'h1);
    w(12'h010, 32'h0);
    w(12'h050, 32'h0);
    w(12'h010, 32'h0);
    rchk(12'h404, 32'h0);
    lvl(4'h2);
    repeat (40) @(posedge aclk);
    chk(u_mem.mem[50], 32'h0);
    w(12'h100, 32'hC);
    w(12'h104, 32'hE0);
    w(12'h108, 32'h0);
    w(12'h10C, 32'h0);
    ext_en <= 12'h010;
    for (i = 0; i < 300 && ext_en_ack[4] !== 1'b1; i++) @(posedge aclk);
    chk(u_mem.mem[56], 32'h0000_C0DE);
    u_mem.mem[56] = 32'h0;
    repeat (40) @(posedge aclk);
    chk(u_mem.mem[56], 32'h0);
    chk({20'h0, ext_en_ack}, 32'h10);
    ext_en <= 12'h000;
    repeat (6) @(posedge aclk);
    chk({20'h0, ext_en_ack}, 32'h0);
    rchk(12'h014, 32'h1);
    u_mem.mem[32] = 32'h0;
    u_mem.mem[33] = 32'h0;
    w(12'h040, 32'h100);
    w(12'h044, 32'hF000_0020);
    w(12'h04C, 32'h0);
    w(12'h050, 32'h1);
    poll(12'h404, 32'h0);
    rchk(12'h004, 32'h80);
    chk(u_mem.mem[32], 32'h0);
    rd(12'h04C, d, r);
    w(12'h04C, d | 32'h10);
    w(12'h010, 32'h1);
    wait_mem(33, 32'h5A5A_0003);
    chk(u_mem.mem[32], 32'hA5A5_0001);
    chk({31'h0, soft_int}, 32'h1);
    wrap_up;
  end
  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    wrap_up;
  end
endmodule // dma_linked_list_flow_control_tb_top
